//--- dirq_osc_div.sv
// Purpose : free-running oscillator clock for the pixel clock pin
// Assumes : half periods are whole cycles of the 200 MHz clock
// Notes   : a select change takes effect within the current half period
`default_nettype none
module dirq_osc_div (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [1:0] freqSel,
  output logic            oscClk
);
  logic [2:0] halfCount;
  logic [2:0] cnt_q;
  logic       osc_q;
  logic       halfDone;

  // ==========================================================
  // half period lookup
  assign halfCount = (freqSel == 2'h0) ? dirq_pkg::HALF00 :
                     (freqSel == 2'h1) ? dirq_pkg::HALF01 :
                     (freqSel == 2'h2) ? dirq_pkg::HALF10 :
                                         dirq_pkg::HALF11;
  // >= guards against a shrink of the select mid period
  assign halfDone  = (cnt_q >= halfCount - 3'h1);

  // toggle each half period
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= 3'h0;
      osc_q <= 1'b0;
    end else if (halfDone) begin
      cnt_q <= 3'h0;
      osc_q <= ~osc_q;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  assign oscClk = osc_q;
endmodule : dirq_osc_div
`default_nettype wire

//--- dirq_pkg.sv
// Purpose : shared constants for the event and pixel clock register bank
// Assumes : 200 MHz system clock, 8-bit register data
// Notes   : offsets are byte addresses on the serial control bus
`default_nettype none
package dirq_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_EVENT_STATUS  = 8'h24;
  localparam logic [7:0] ADDR_FSYNC_CONFIG  = 8'h25;
  localparam logic [7:0] ADDR_PCLK_CONTROL  = 8'h3b;
  localparam logic [7:0] ADDR_FREQ_DET_LOW  = 8'h3c;

  // ==========================================================
  // field positions
  localparam int GLOBAL_FLAG_BIT  = 7;
  localparam int PORT1_FLAG_BIT   = 1;
  localparam int PORT0_FLAG_BIT   = 0;
  localparam int FSYNC_EDGE_BIT   = 6;
  localparam int UNLOCK_CLK_BIT   = 4;
  localparam int OSC_SEL_HI_BIT   = 3;
  localparam int OSC_SEL_LO_BIT   = 2;
  localparam int OSC_EN_BIT       = 1;
  localparam int EDGE_SEL_BIT     = 0;
  localparam int THRESH_HI_BIT    = 4;

  // ==========================================================
  // reset values
  localparam logic       FSYNC_EDGE_RST  = 1'b0;
  localparam logic       UNLOCK_CLK_RST  = 1'b0;
  localparam logic [1:0] OSC_SEL_RST     = 2'h0;
  localparam logic       OSC_EN_RST      = 1'b0;
  localparam logic       EDGE_SEL_RST    = 1'b1;
  localparam logic [4:0] THRESH_RST      = 5'h14;

  // ==========================================================
  // oscillator output frequencies and their half periods in cycles
  localparam int CLK_KHZ      = 200000;
  localparam int OSC00_KHZ    = 50000;
  localparam int OSC01_KHZ    = 25000;
  localparam int OSC10_KHZ    = 100000;
  localparam int OSC11_KHZ    = 33300;
  localparam logic [2:0] HALF00 = 3'(CLK_KHZ / (2 * OSC00_KHZ));
  localparam logic [2:0] HALF01 = 3'(CLK_KHZ / (2 * OSC01_KHZ));
  localparam logic [2:0] HALF10 = 3'(CLK_KHZ / (2 * OSC10_KHZ));
  localparam logic [2:0] HALF11 = 3'(CLK_KHZ / (2 * OSC11_KHZ));
endpackage : dirq_pkg
`default_nettype wire

//--- dirq_regs.sv
// Purpose : event flags, frame sync edge and pixel clock control registers
// Assumes : register port comes from the serial control bus front end
// Notes   : per-port enables and master enable live in another register
//
// Function
// RULE1: global flag bit 7 set when any enabled port flag is set.
// RULE2: global flag ignores master enable but honours per-port enables.
// RULE3: port flags bits 1 and 0 rise on port events; read-only.
// RULE4: port flag clears only by reading that port's status registers.
// RULE5: frame sync edge bit 6: 0 rising edge, 1 falling edge.
// RULE6: bit 4 lets recovered clock reach pixel clock pin without lock.
// RULE7: bits 3:2 pick oscillator 50, 25, 100 or 33.3 MHz.
// RULE8: bit 1 drives oscillator when unlocked and state select low.
// RULE9: edge select bit 0, reset 1, launches data on falling edge.
// RULE10: threshold bits 4:0, reset 0x14 MHz, flags too-low clock.
// RULE11: master enable gates global event onto interrupt output.
// RULE12: per-port enables let each port feed the global flag.
// RULE13: reserved bits read zero and ignore writes.
`default_nettype none
module dirq_regs (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrEn,
  input  wire logic [7:0] regWrData,
  input  wire logic       regRdEn,
  output logic      [7:0] regRdData,
  input  wire logic [1:0] portEvent,
  input  wire logic [1:0] portStatusRead,
  input  wire logic [1:0] portEventEnable,
  input  wire logic       masterEventEnable,
  output logic            eventIrq,
  input  wire logic       frameSyncIn,
  output logic            frameSyncStrobe,
  input  wire logic       linkLocked,
  input  wire logic       outputStateSelect,
  input  wire logic       recoveredClock,
  output logic            pixelClockPin,
  output logic            dataLaunchFalling,
  input  wire logic [7:0] recClockMhz,
  output logic            clockTooLow
);
  // ==========================================================
  // state
  logic [1:0] flag_q;
  logic [1:0] flag_d;
  logic       fsEdge_q;
  logic       unlockClk_q;
  logic [1:0] oscSel_q;
  logic       oscEn_q;
  logic       edgeSel_q;
  logic [4:0] thresh_q;
  logic [7:0] rdData_q;
  logic       fsPrev_q;
  logic       fsStrobe_q;
  logic       pclk_q;
  logic       tooLow_q;

  logic       globalFlag;
  logic       wrFsync;
  logic       wrPclk;
  logic       wrFreq;
  logic [7:0] rdMux;
  logic       oscClk;
  logic       fsRise;
  logic       fsFall;
  logic       pclkNext;

  // ==========================================================
  // event flags
  // a new event in the clearing cycle wins so nothing is lost
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : gFlag
      assign flag_d[p] = portEvent[p] |                        // RULE3
                         (flag_q[p] & ~portStatusRead[p]);     // RULE4
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (srst) flag_q <= 2'h0;
    else      flag_q <= flag_d;
  end

  // global flag is a view, so it tracks enable changes at once
  assign globalFlag = |(flag_q & portEventEnable);  // RULE1 RULE2 RULE12
  assign eventIrq   = globalFlag & masterEventEnable;          // RULE11

  // ==========================================================
  // register write decode
  assign wrFsync = regWrEn & (regAddr == dirq_pkg::ADDR_FSYNC_CONFIG);
  assign wrPclk  = regWrEn & (regAddr == dirq_pkg::ADDR_PCLK_CONTROL);
  assign wrFreq  = regWrEn & (regAddr == dirq_pkg::ADDR_FREQ_DET_LOW);

  // only defined bits are stored; reserved bits drop
  always_ff @(posedge clk) begin
    if (srst) begin
      fsEdge_q    <= dirq_pkg::FSYNC_EDGE_RST;
      unlockClk_q <= dirq_pkg::UNLOCK_CLK_RST;
      oscSel_q    <= dirq_pkg::OSC_SEL_RST;
      oscEn_q     <= dirq_pkg::OSC_EN_RST;
      edgeSel_q   <= dirq_pkg::EDGE_SEL_RST;               // RULE9
      thresh_q    <= dirq_pkg::THRESH_RST;                 // RULE10
    end else begin
      if (wrFsync) fsEdge_q <= regWrData[dirq_pkg::FSYNC_EDGE_BIT];
      if (wrPclk) begin
        unlockClk_q <= regWrData[dirq_pkg::UNLOCK_CLK_BIT];
        oscSel_q    <= regWrData[dirq_pkg::OSC_SEL_HI_BIT:
                                 dirq_pkg::OSC_SEL_LO_BIT];
        oscEn_q     <= regWrData[dirq_pkg::OSC_EN_BIT];
        edgeSel_q   <= regWrData[dirq_pkg::EDGE_SEL_BIT];
      end
      if (wrFreq) thresh_q <= regWrData[dirq_pkg::THRESH_HI_BIT:0];
    end
  end

  // ==========================================================
  // read mux, reserved bits and unmapped addresses read zero
  assign rdMux =
    (regAddr == dirq_pkg::ADDR_EVENT_STATUS) ?
      {globalFlag, 5'h00, flag_q} :                              // RULE13
    (regAddr == dirq_pkg::ADDR_FSYNC_CONFIG) ?
      {1'b0, fsEdge_q, 6'h00} :
    (regAddr == dirq_pkg::ADDR_PCLK_CONTROL) ?
      {3'h0, unlockClk_q, oscSel_q, oscEn_q, edgeSel_q} :
    (regAddr == dirq_pkg::ADDR_FREQ_DET_LOW) ?
      {3'h0, thresh_q} : 8'h00;

  // read data held until the next read
  always_ff @(posedge clk) begin
    if (srst)         rdData_q <= 8'h00;
    else if (regRdEn) rdData_q <= rdMux;
  end
  assign regRdData = rdData_q;

  // ==========================================================
  // frame sync active edge
  assign fsRise = frameSyncIn & ~fsPrev_q;
  assign fsFall = ~frameSyncIn & fsPrev_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      fsPrev_q   <= 1'b0;
      fsStrobe_q <= 1'b0;
    end else begin
      fsPrev_q   <= frameSyncIn;
      fsStrobe_q <= fsEdge_q ? fsFall : fsRise;               // RULE5
    end
  end
  assign frameSyncStrobe = fsStrobe_q;

  // ==========================================================
  // pixel clock pin source
  dirq_osc_div u_dirq_osc_div (
    .clk     (clk),
    .srst    (srst),
    .freqSel (oscSel_q),                                      // RULE7
    .oscClk  (oscClk)
  );

  // locked link always passes the recovered clock
  assign pclkNext =
    (linkLocked | unlockClk_q) ? recoveredClock :            // RULE6
    (oscEn_q & ~outputStateSelect) ? oscClk : 1'b0;          // RULE8

  always_ff @(posedge clk) begin
    if (srst) pclk_q <= 1'b0;
    else      pclk_q <= pclkNext;
  end
  assign pixelClockPin     = pclk_q;
  assign dataLaunchFalling = edgeSel_q;                       // RULE9

  // ==========================================================
  // low frequency judgement, compare against whole MHz
  always_ff @(posedge clk) begin
    if (srst) tooLow_q <= 1'b0;
    else      tooLow_q <= (recClockMhz < {3'h0, thresh_q});   // RULE10
  end
  assign clockTooLow = tooLow_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  chk_flag_sets: assert property (                             // RULE3
    portEvent[0] |=> flag_q[0])
    else $error("port0 event did not set its flag");
  chk_flag_holds: assert property (                            // RULE4
    flag_q[1] && !portStatusRead[1] |=> flag_q[1])
    else $error("port1 flag dropped without status read");
  chk_flag_clears: assert property (                           // RULE4
    portStatusRead[0] && !portEvent[0] |=> !flag_q[0])
    else $error("port0 flag kept after status read");
  chk_global_flag: assert property (                           // RULE1
    (flag_q[1] && portEventEnable[1]) |-> rdMux[7] ||
      regAddr != dirq_pkg::ADDR_EVENT_STATUS)
    else $error("global flag missing for enabled port");
  chk_global_masked: assert property (                         // RULE12
    portEventEnable == 2'h0 |-> !globalFlag)
    else $error("global flag set with ports disabled");
  chk_irq_gate: assert property (                              // RULE11
    eventIrq |-> masterEventEnable && globalFlag)
    else $error("interrupt without master enable");
  chk_irq_indep: assert property (                             // RULE2
    !masterEventEnable && (flag_q[0] && portEventEnable[0]) |-> globalFlag)
    else $error("global flag depends on master enable");
  chk_fs_edge: assert property (                               // RULE5
    fsEdge_q && $fell(frameSyncIn) && $stable(fsEdge_q) |=> frameSyncStrobe)
    else $error("falling frame sync edge missed");
  chk_pclk_osc: assert property (                              // RULE8
    !linkLocked && !unlockClk_q && !oscEn_q |=> !pixelClockPin)
    else $error("pixel clock driven while unlocked and disabled");
  chk_pclk_unlock: assert property (                           // RULE6
    unlockClk_q && !srst |=> pixelClockPin == $past(recoveredClock))
    else $error("recovered clock not passed without lock");
  chk_osc_100: assert property (                               // RULE7
    oscSel_q == 2'h2 && $stable(oscSel_q) |=> oscClk != $past(oscClk))
    else $error("100 MHz oscillator not toggling each cycle");
  chk_thresh_cmp: assert property (                            // RULE10
    recClockMhz < {3'h0, thresh_q} && $stable(thresh_q) |=> clockTooLow)
    else $error("low clock not flagged");
  chk_rsvd_zero: assert property (                             // RULE13
    regRdEn && regAddr == dirq_pkg::ADDR_PCLK_CONTROL |=>
      regRdData[7:5] == 3'h0)
    else $error("reserved bits read nonzero");

  cov_irq: cover property (eventIrq);
  cov_clear: cover property (flag_q[0] ##1 portStatusRead[0] ##1 !flag_q[0]);
  cov_set_clear: cover property (portEvent[1] && portStatusRead[1]);
  cov_osc_out: cover property (!linkLocked && oscEn_q && pixelClockPin);
endmodule : dirq_regs
`default_nettype wire

//--- dirq_regs_tb_top.sv
// Purpose : self-checking bench for the event and pixel clock registers
// Assumes : dirq_pkg and dirq_regs are compiled first
// Notes   : every input moves 1 ns after the rising edge of clk
`default_nettype none
module dirq_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic       regWrEn = 1'b0;
  logic [7:0] regWrData = 8'h00;
  logic       regRdEn = 1'b0;
  logic [7:0] regRdData;
  logic [1:0] portEvent = 2'h0;
  logic [1:0] portStatusRead = 2'h0;
  logic [1:0] portEventEnable = 2'h0;
  logic       masterEventEnable = 1'b0;
  logic       eventIrq;
  logic       frameSyncIn = 1'b0;
  logic       frameSyncStrobe;
  logic       linkLocked = 1'b0;
  logic       outputStateSelect = 1'b0;
  logic       recoveredClock = 1'b0;
  logic       pixelClockPin;
  logic       dataLaunchFalling;
  logic [7:0] recClockMhz = 8'h40;
  logic       clockTooLow;
  int         badCount = 0;
  int         checked = 0;
  dirq_regs u_dirq_regs (.clk(clk), .srst(srst), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData(regRdData), .portEvent(portEvent),
    .portStatusRead(portStatusRead), .portEventEnable(portEventEnable),
    .masterEventEnable(masterEventEnable), .eventIrq(eventIrq),
    .frameSyncIn(frameSyncIn), .frameSyncStrobe(frameSyncStrobe),
    .linkLocked(linkLocked), .outputStateSelect(outputStateSelect),
    .recoveredClock(recoveredClock), .pixelClockPin(pixelClockPin),
    .dataLaunchFalling(dataLaunchFalling), .recClockMhz(recClockMhz),
    .clockTooLow(clockTooLow));
  // 200 MHz clock
  always #2.5 clk = ~clk;
  // ==========================================================
  // shared tasks
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] %0t seen %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // strobes drop and one edge passes, so a next call never doubles them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    tick(1);
    regWrEn = 1'b0;
    tick(1);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    regAddr = a;
    regRdEn = 1'b1;
    tick(1);
    regRdEn = 1'b0;
    chk(regRdData, exp);
    tick(1);
  endtask : rdc
  // frame sync input moves; the strobe stands for the cycle after the edge
  // that first sees the change, then drops
  task automatic fs(input logic v, input logic pulse);
    frameSyncIn = v;
    tick(1);
    chk(8'(frameSyncStrobe), 8'(pulse));
    tick(1);
    chk(8'(frameSyncStrobe), 8'h00);
    tick(1);
    chk(8'(frameSyncStrobe), 8'h00);
  endtask : fs
  // cycles between two toggles of the pin, bounded at 20
  task automatic halfPeriod(output int n);
    logic p;
    n = 0;
    p = pixelClockPin;
    for (int i = 0; i < 20 && pixelClockPin === p; i++) tick(1);
    p = pixelClockPin;
    for (int i = 0; i < 20 && pixelClockPin === p; i++) begin
      tick(1);
      n++;
    end
  endtask : halfPeriod
  // ==========================================================
  // scenarios
  task automatic tEvents;
    portEventEnable = 2'b01;
    masterEventEnable = 1'b1;
    portEvent = 2'b10;
    tick(1);
    portEvent = 2'b00;
    rdc(8'h24, 8'h02);
    chk(8'(eventIrq), 8'h00);
    portEvent = 2'b01;
    tick(1);
    portEvent = 2'b00;
    chk(8'(eventIrq), 8'h01);
    rdc(8'h24, 8'h83);
    masterEventEnable = 1'b0;
    rdc(8'h24, 8'h83);
    chk(8'(eventIrq), 8'h00);
    portStatusRead = 2'b01;
    tick(1);
    portStatusRead = 2'b00;
    rdc(8'h24, 8'h02);
    portEventEnable = 2'b10;
    rdc(8'h24, 8'h82);
    portStatusRead = 2'b10;
    portEvent = 2'b10;
    tick(1);
    portEvent = 2'b00;
    portStatusRead = 2'b00;
    rdc(8'h24, 8'h82);
    portStatusRead = 2'b10;
    tick(1);
    portStatusRead = 2'b00;
    rdc(8'h24, 8'h00);
    wr(8'h24, 8'hff);
    rdc(8'h24, 8'h00);
  endtask : tEvents
  task automatic tClocks;
    int n;
    logic [2:0] halfExp [4] = '{3'h2, 3'h4, 3'h1, 3'h3};
    wr(8'h3b, 8'hff);
    rdc(8'h3b, 8'h1f);
    chk(8'(dataLaunchFalling), 8'h01);
    wr(8'h3b, 8'h00);
    chk(8'(dataLaunchFalling), 8'h00);
    for (int i = 0; i < 6; i++) begin
      recoveredClock = i[0];
      // lock drops before the last two steps so only bit 4 passes the clock
      linkLocked = (i > 1) && (i < 4);
      if (i == 4) wr(8'h3b, 8'h10);
      if (i == 4) linkLocked = 1'b0;
      tick(1);
      chk(8'(pixelClockPin), 8'(i > 1 ? i[0] : 1'b0));
    end
    for (int s = 0; s < 4; s++) begin
      wr(8'h3b, {4'h0, 2'(s), 2'b10});
      tick(8);
      halfPeriod(n);
      chk(8'(n), 8'(halfExp[s]));
    end
    outputStateSelect = 1'b1;
    tick(2);
    for (int i = 0; i < 4; i++) begin
      tick(1);
      chk(8'(pixelClockPin), 8'h00);
    end
  endtask : tClocks
  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    #1;
    srst = 1'b0;
    rdc(8'h24, 8'h00);
    rdc(8'h25, 8'h00);
    rdc(8'h3b, 8'h01);
    rdc(8'h3c, 8'h14);
    rdc(8'h30, 8'h00);
    tEvents();
    wr(8'h25, 8'hff);
    rdc(8'h25, 8'h40);
    fs(1'b1, 1'b0);
    fs(1'b0, 1'b1);
    wr(8'h25, 8'h00);
    fs(1'b1, 1'b1);
    fs(1'b0, 1'b0);
    tClocks();
    recClockMhz = 8'd19;
    tick(2);
    chk(8'(clockTooLow), 8'h01);
    recClockMhz = 8'd20;
    tick(2);
    chk(8'(clockTooLow), 8'h00);
    wr(8'h3c, 8'hff);
    rdc(8'h3c, 8'h1f);
    conclude();
  end
  // watchdog: a hang counts as a mismatch
  initial begin
    #200us;
    badCount++;
    conclude();
  end
endmodule : dirq_regs_tb_top
`default_nettype wire
